/* File: core/timer8_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none
module timer8_prescaler
    import timer8_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [2:0] i_clk_sel,
    input wire logic i_ext_pin,
    output logic o_tick
);

    presc_state_t s_r;
    presc_state_t s_nxt;

    // -------------------------------------------------------------------------
    // Divider.
    // -------------------------------------------------------------------------
    // The divider runs free so every divided source shares one phase, as a common prescaler would.
    always_comb begin
        s_nxt = s_r;
        s_nxt.cnt = s_r.cnt + 10'h001;
        s_nxt.ext_prev = i_ext_pin;
        unique case (clk_sel_t'(i_clk_sel))
            CS_STOP: s_nxt.tick = 1'b0;
            CS_DIV1: s_nxt.tick = 1'b1;
            CS_DIV8: s_nxt.tick = (s_r.cnt & PRE_MASK_8) == PRE_MASK_8;
            CS_DIV64: s_nxt.tick = (s_r.cnt & PRE_MASK_64) == PRE_MASK_64;
            CS_DIV256: s_nxt.tick = (s_r.cnt & PRE_MASK_256) == PRE_MASK_256;
            CS_DIV1024: s_nxt.tick = (s_r.cnt & PRE_MASK_1024) == PRE_MASK_1024;
            CS_EXT_FALL: s_nxt.tick = s_r.ext_prev & ~i_ext_pin;
            CS_EXT_RISE: s_nxt.tick = ~s_r.ext_prev & i_ext_pin;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_tick = s_r.tick;

endmodule // timer8_prescaler
`default_nettype wire

/* File: core/timer8_wave_ctrl.sv */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module timer8_wave_ctrl
    import timer8_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic i_ext_pin,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_wave_out_a,
    output logic o_wave_out_b,
    output logic o_wave_en_a,
    output logic o_wave_en_b,
    output logic o_overflow_flag,
    output logic o_match_a_flag,
    output logic o_match_b_flag
);

    timer_state_t s_r;
    timer_state_t s_nxt;
    logic tick;

    // -------------------------------------------------------------------------
    // Helpers.
    // -------------------------------------------------------------------------
    function automatic reg_sel_t decode(input logic [7:0] addr);
        reg_sel_t r;
        r = SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            if (addr == ADDR_CTRL_A) r = SEL_CTRL_A;
            else if (addr == ADDR_CTRL_B) r = SEL_CTRL_B;
            else if (addr == ADDR_COUNTER) r = SEL_COUNTER;
            else if (addr == ADDR_CMP_A) r = SEL_CMP_A;
            else if (addr == ADDR_CMP_B) r = SEL_CMP_B;
            else if (addr == ADDR_FLAGS) r = SEL_FLAGS;
        end
        return r;
    endfunction

    // Next level of one waveform output from its mode code and this tick's events.
    function automatic logic chan_next(
        input logic cur,
        input logic [1:0] com,
        input logic hit,
        input logic top_eq,
        input logic at_top,
        input logic down,
        input logic tog_ok,
        input wave_mode_t m
    );
        logic r;
        r = cur;
        unique case (m)
            MODE_FAST_FF, MODE_FAST_CMPA: begin
                if (com == 2'h1) begin
                    if (hit && tog_ok) r = ~cur;
                end else if (com[1]) begin
                    if (at_top) r = ~com[0];
                    else if (hit && !top_eq) r = com[0];
                end
            end
            MODE_PHASE_FF, MODE_PHASE_CMPA: begin
                if (com == 2'h1) begin
                    if (hit && tog_ok) r = ~cur;
                end else if (com[1]) begin
                    if (top_eq) begin
                        if (at_top) r = ~com[0];
                    end else if (hit) begin
                        r = down ? ~com[0] : com[0];
                    end
                end
            end
            MODE_NORMAL, MODE_CLEAR_ON_MATCH, MODE_RSVD_4, MODE_RSVD_6: begin
                if (hit) begin
                    if (com == 2'h1) r = ~cur;
                    else if (com[1]) r = com[0];
                end
            end
        endcase
        return r;
    endfunction

    // -------------------------------------------------------------------------
    // Timer clock enable.
    // -------------------------------------------------------------------------
    timer8_prescaler timer8_prescaler_i (
        .i_mclk(i_mclk),
        .i_rst_b(i_rst_b),
        .i_clk_sel(s_r.clk_sel),
        .i_ext_pin(i_ext_pin),
        .o_tick(tick)
    );

    // -------------------------------------------------------------------------
    // Next state.
    // -------------------------------------------------------------------------
    always_comb begin
        wave_mode_t mode;
        logic [7:0] top;
        logic at_top;
        logic at_bottom;
        logic hit_a;
        logic hit_b;
        logic set_ovf;
        logic is_phase;
        logic is_fast;
        logic do_wr;
        logic [2:0] clr;
        reg_sel_t wsel;
        reg_sel_t rsel;
        s_nxt = s_r;
        mode = wave_mode_t'({s_r.wave_mode_high_bit, s_r.wave_mode_low_bits});
        top = CNT_MAX;
        is_phase = 1'b0;
        is_fast = 1'b0;
        set_ovf = 1'b0;
        clr = 3'h0;
        unique case (mode)
            MODE_NORMAL, MODE_FAST_FF, MODE_PHASE_FF: top = CNT_MAX;
            MODE_CLEAR_ON_MATCH: top = s_r.act_a;
            MODE_PHASE_CMPA, MODE_FAST_CMPA: top = s_r.act_a;
            MODE_RSVD_4, MODE_RSVD_6: top = CNT_MAX;
        endcase
        is_phase = (mode == MODE_PHASE_FF) || (mode == MODE_PHASE_CMPA);
        is_fast = (mode == MODE_FAST_FF) || (mode == MODE_FAST_CMPA);
        at_top = tick && (s_r.counter_value == top);
        at_bottom = tick && (s_r.counter_value == CNT_BOTTOM);
        hit_a = tick && !s_r.match_block && (s_r.counter_value == s_r.act_a);
        hit_b = tick && !s_r.match_block && (s_r.counter_value == s_r.act_b);

        // Counting sequence.
        if (tick) begin
            s_nxt.match_block = 1'b0;
            if (is_phase) begin
                if (top == CNT_BOTTOM) begin
                    s_nxt.counter_value = CNT_BOTTOM;
                end else if (!s_r.count_down) begin
                    if (s_r.counter_value == top) begin
                        s_nxt.count_down = 1'b1;
                        s_nxt.counter_value = s_r.counter_value - 8'h01;
                    end else begin
                        s_nxt.counter_value = s_r.counter_value + 8'h01;
                    end
                end else if (s_r.counter_value == CNT_BOTTOM) begin
                    s_nxt.count_down = 1'b0;
                    s_nxt.counter_value = CNT_BOTTOM + 8'h01;
                end else begin
                    s_nxt.counter_value = s_r.counter_value - 8'h01;
                end
            end else begin
                s_nxt.count_down = 1'b0;
                s_nxt.counter_value = (s_r.counter_value == top) ? CNT_BOTTOM : s_r.counter_value + 8'h01;
            end
        end

        // Overflow flag source.
        unique case (mode)
            MODE_NORMAL, MODE_CLEAR_ON_MATCH, MODE_FAST_FF: set_ovf = tick && (s_r.counter_value == CNT_MAX);
            MODE_PHASE_FF, MODE_PHASE_CMPA: set_ovf = at_bottom;
            MODE_FAST_CMPA: set_ovf = at_top;
            MODE_RSVD_4, MODE_RSVD_6: set_ovf = 1'b0;
        endcase

        // Compare buffers move to the active copies at the mode's update point.
        if ((is_phase || is_fast) && at_top) begin
            s_nxt.act_a = s_r.buf_a;
            s_nxt.act_b = s_r.buf_b;
        end

        // Waveform outputs.
        s_nxt.wave_out_a = chan_next(s_r.wave_out_a, s_r.out_mode_chan_a, hit_a, s_r.act_a == top, at_top,
                                     s_r.count_down, s_r.wave_mode_high_bit, mode);
        s_nxt.wave_out_b = chan_next(s_r.wave_out_b, s_r.out_mode_chan_b, hit_b, s_r.act_b == top, at_top,
                                     s_r.count_down, 1'b0, mode);

        // Write channel: address and data are taken independently, then committed together.
        if (i_awvalid && s_r.awready) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.awaddr = i_awaddr;
        end
        if (i_wvalid && s_r.wready) begin
            s_nxt.w_full = 1'b1;
            s_nxt.wdata = i_wdata[7:0];
            s_nxt.wstrb0 = i_wstrb[0];
        end
        if (s_r.bvalid && i_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        do_wr = s_r.aw_full && s_r.w_full && !s_r.bvalid;
        wsel = decode(s_r.awaddr);
        if (do_wr) begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (s_r.wstrb0) begin
                unique case (wsel)
                    SEL_CTRL_A: begin
                        s_nxt.out_mode_chan_a = s_r.wdata[CTRL_A_OUT_A_LSB +: 2];
                        s_nxt.out_mode_chan_b = s_r.wdata[CTRL_A_OUT_B_LSB +: 2];
                        s_nxt.wave_mode_low_bits = s_r.wdata[CTRL_A_WAVE_LSB +: 2];
                    end
                    SEL_CTRL_B: begin
                        s_nxt.wave_mode_high_bit = s_r.wdata[CTRL_B_WAVE_HIGH];
                        s_nxt.clk_sel = s_r.wdata[CTRL_B_CLK_LSB +: 3];
                    end
                    SEL_COUNTER: begin
                        // A software write wins over the tick and hides the next match.
                        s_nxt.counter_value = s_r.wdata;
                        s_nxt.match_block = 1'b1;
                    end
                    SEL_CMP_A: s_nxt.buf_a = s_r.wdata;
                    SEL_CMP_B: s_nxt.buf_b = s_r.wdata;
                    SEL_FLAGS: clr = s_r.wdata[2:0];
                    SEL_NONE: clr = 3'h0;
                endcase
            end
        end
        s_nxt.awready = !s_nxt.aw_full;
        s_nxt.wready = !s_nxt.w_full;

        // Flags: a hardware set in the same cycle beats a write-one clear.
        s_nxt.overflow_flag = (s_r.overflow_flag & ~clr[FLAG_OVERFLOW]) | set_ovf;
        s_nxt.match_a_flag = (s_r.match_a_flag & ~clr[FLAG_MATCH_A]) | hit_a;
        s_nxt.match_b_flag = (s_r.match_b_flag & ~clr[FLAG_MATCH_B]) | hit_b;

        // Non-PWM modes use the written compare value at once.
        if (!is_phase && !is_fast) begin
            s_nxt.act_a = s_nxt.buf_a;
            s_nxt.act_b = s_nxt.buf_b;
        end

        // Every PWM mode has the low mode bit set; code 1 there needs the high bit for channel A to own its pin.
        s_nxt.wave_en_a = (|s_nxt.out_mode_chan_a) && !((s_nxt.out_mode_chan_a == 2'h1)
                          && s_nxt.wave_mode_low_bits[0] && !s_nxt.wave_mode_high_bit);
        s_nxt.wave_en_b = |s_nxt.out_mode_chan_b;

        // Read channel.
        if (s_r.rvalid && i_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        rsel = decode(i_araddr);
        if (i_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            unique case (rsel)
                SEL_CTRL_A: s_nxt.rdata = {s_r.out_mode_chan_a, s_r.out_mode_chan_b, 2'h0,
                                           s_r.wave_mode_low_bits};
                SEL_CTRL_B: s_nxt.rdata = {4'h0, s_r.wave_mode_high_bit, s_r.clk_sel};
                SEL_COUNTER: s_nxt.rdata = s_r.counter_value;
                SEL_CMP_A: s_nxt.rdata = s_r.buf_a;
                SEL_CMP_B: s_nxt.rdata = s_r.buf_b;
                SEL_FLAGS: s_nxt.rdata = {5'h00, s_r.match_b_flag, s_r.match_a_flag, s_r.overflow_flag};
                SEL_NONE: s_nxt.rdata = REG_RESET;
            endcase
        end
        s_nxt.arready = !s_nxt.rvalid;
    end

    // -------------------------------------------------------------------------
    // State register.
    // -------------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // Outputs.
    // -------------------------------------------------------------------------
    // The pin driver itself sits in the port block, which also needs its direction bit set.
    assign o_wave_out_a = s_r.wave_out_a;
    assign o_wave_out_b = s_r.wave_out_b;
    assign o_wave_en_a = s_r.wave_en_a;
    assign o_wave_en_b = s_r.wave_en_b;
    assign o_overflow_flag = s_r.overflow_flag;
    assign o_match_a_flag = s_r.match_a_flag;
    assign o_match_b_flag = s_r.match_b_flag;
    assign o_awready = s_r.awready;
    assign o_wready = s_r.wready;
    assign o_bvalid = s_r.bvalid;
    assign o_bresp = s_r.bresp;
    assign o_arready = s_r.arready;
    assign o_rvalid = s_r.rvalid;
    assign o_rresp = s_r.rresp;
    assign o_rdata = {24'h000000, s_r.rdata};

endmodule // timer8_wave_ctrl
`default_nettype wire

/* File: shared/timer8_pkg.sv */
package timer8_pkg;

    // -------------------------------------------------------------------------
    // Register map, byte addresses on the AXI4-Lite bus.
    // -------------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL_A = 8'h30;
    localparam logic [7:0] ADDR_CTRL_B = 8'h34;
    localparam logic [7:0] ADDR_COUNTER = 8'h38;
    localparam logic [7:0] ADDR_CMP_A = 8'h3c;
    localparam logic [7:0] ADDR_CMP_B = 8'h40;
    localparam logic [7:0] ADDR_FLAGS = 8'h44;

    // -------------------------------------------------------------------------
    // Field positions.
    // -------------------------------------------------------------------------
    localparam int CTRL_A_OUT_A_LSB = 6;
    localparam int CTRL_A_OUT_B_LSB = 4;
    localparam int CTRL_A_WAVE_LSB = 0;
    localparam int CTRL_B_WAVE_HIGH = 3;
    localparam int CTRL_B_CLK_LSB = 0;
    localparam int FLAG_OVERFLOW = 0;
    localparam int FLAG_MATCH_A = 1;
    localparam int FLAG_MATCH_B = 2;

    // -------------------------------------------------------------------------
    // Values and counts.
    // -------------------------------------------------------------------------
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;

    // -------------------------------------------------------------------------
    // Enumerations.
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_PHASE_FF = 3'h1,
        MODE_CLEAR_ON_MATCH = 3'h2,
        MODE_FAST_FF = 3'h3,
        MODE_RSVD_4 = 3'h4,
        MODE_PHASE_CMPA = 3'h5,
        MODE_RSVD_6 = 3'h6,
        MODE_FAST_CMPA = 3'h7
    } wave_mode_t;

    typedef enum logic [2:0] {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clk_sel_t;

    typedef enum logic [2:0] {
        SEL_CTRL_A = 3'h0,
        SEL_CTRL_B = 3'h1,
        SEL_COUNTER = 3'h2,
        SEL_CMP_A = 3'h3,
        SEL_CMP_B = 3'h4,
        SEL_FLAGS = 3'h5,
        SEL_NONE = 3'h6
    } reg_sel_t;

    // -------------------------------------------------------------------------
    // State carriers.
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [9:0] cnt;
        logic ext_prev;
        logic tick;
    } presc_state_t;

    typedef struct packed {
        logic [1:0] out_mode_chan_a;
        logic [1:0] out_mode_chan_b;
        logic [1:0] wave_mode_low_bits;
        logic wave_mode_high_bit;
        logic [2:0] clk_sel;
        logic [7:0] counter_value;
        logic count_down;
        logic [7:0] buf_a;
        logic [7:0] buf_b;
        logic [7:0] act_a;
        logic [7:0] act_b;
        logic match_block;
        logic overflow_flag;
        logic match_a_flag;
        logic match_b_flag;
        logic wave_out_a;
        logic wave_out_b;
        logic wave_en_a;
        logic wave_en_b;
        logic aw_full;
        logic [7:0] awaddr;
        logic awready;
        logic w_full;
        logic [7:0] wdata;
        logic wstrb0;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
    } timer_state_t;

endpackage

/* File: verif/timer8_wave_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module timer8_wave_ctrl_asserts
    import timer8_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic o_wave_out_a,
    input wire logic o_wave_en_a,
    input wire logic o_wave_en_b,
    input wire logic o_overflow_flag
);
    // ------------------------------------------------------------------
    // Address capture and checks.
    // ------------------------------------------------------------------
    // Addresses are latched at acceptance so responses can be judged later.
    logic [7:0] rd_addr_r;
    logic [7:0] wr_addr_r;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_addr_r <= 8'h00;
            wr_addr_r <= 8'h00;
        end else begin
            if (i_arvalid && o_arready) rd_addr_r <= i_araddr;
            if (i_awvalid && o_awready) wr_addr_r <= i_awaddr;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    property p_rd_hi; o_rvalid |-> o_rdata[31:8] == 24'h000000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("read upper bits not zero");
    property p_rsvd; o_rvalid && rd_addr_r == ADDR_CTRL_A |-> o_rdata[3:2] == 2'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
    property p_rd_lat; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
    property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response not held");
    property p_wr_lat;
        i_awvalid && o_awready && i_wvalid && o_wready && !o_bvalid |-> ##[1:2] o_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_unmapped; o_bvalid && wr_addr_r > ADDR_FLAGS |-> o_bresp == RESP_SLVERR; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");
    property p_en_a; $changed(o_wave_en_a) |-> o_bvalid || $past(o_bvalid); endproperty
    a_en_a: assert property (p_en_a) else $error("pin A ownership moved without write");
    property p_en_b; $changed(o_wave_en_b) |-> o_bvalid || $past(o_bvalid); endproperty
    a_en_b: assert property (p_en_b) else $error("pin B ownership moved without write");
    property p_ovf; $fell(o_overflow_flag) |-> o_bvalid || $past(o_bvalid); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag dropped without write");
    c_rd: cover property (i_arvalid && o_arready);
    c_slverr: cover property (o_bvalid && o_bresp == RESP_SLVERR);
    c_ovf: cover property ($rose(o_overflow_flag));
    c_wave: cover property ($changed(o_wave_out_a));
endmodule // timer8_wave_ctrl_asserts
bind timer8_wave_ctrl timer8_wave_ctrl_asserts timer8_wave_ctrl_asserts_i (
    .i_mclk, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
    .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_wave_out_a,
    .o_wave_en_a, .o_wave_en_b, .o_overflow_flag
);
`default_nettype wire

/* File: verif/timer8_wave_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module timer8_wave_ctrl_bench
    import timer8_pkg::*;
;
    // ------------------------------------------------------------------
    // Stimulus and checking.
    // ------------------------------------------------------------------
    logic i_mclk, i_rst_b, i_ext_pin, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr, hb, rv;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wave_out_a, o_wave_out_b;
    logic o_wave_en_a, o_wave_en_b, o_overflow_flag, o_match_a_flag, o_match_b_flag, exp_a;
    int n_mismatch, tests_run;
    logic [7:0] tbl [5] = '{8'hff, 8'h40, 8'h10, 8'h43, 8'h83};
    logic [1:0] cds [4] = '{2'h3, 2'h2, 2'h1, 2'h0};
    logic [2:0] mds [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    logic ovx [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    timer8_wave_ctrl timer8_wave_ctrl_i (
        .i_mclk, .i_rst_b, .i_ext_pin, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
        .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_wave_out_a, .o_wave_out_b, .o_wave_en_a,
        .o_wave_en_b, .o_overflow_flag, .o_match_a_flag, .o_match_b_flag
    );
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge i_mclk);
        i_awaddr <= a;
        i_awvalid <= 1'b1;
        i_wdata <= {24'h0, d};
        i_wvalid <= 1'b1;
        do begin
            @(posedge i_mclk);
            if (o_awready === 1'b1) i_awvalid <= 1'b0;
            if (o_wready === 1'b1) i_wvalid <= 1'b0;
        end while (i_awvalid || i_wvalid);
        do @(posedge i_mclk); while (o_bvalid !== 1'b1);
        i_bready <= 1'b1;
        @(posedge i_mclk);
        i_bready <= 1'b0;
        chk({30'h0, o_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        do @(posedge i_mclk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_mclk); while (o_rvalid !== 1'b1);
        i_rready <= 1'b1;
        @(posedge i_mclk);
        i_rready <= 1'b0;
        chk(o_rdata, {24'h0, d});
        chk({30'h0, o_rresp}, {30'h0, er});
    endtask
    task automatic do_reset;
        i_rst_b <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_rst_b <= 1'b1;
    endtask
    // The high mode bit shares control B with the clock select, so runs keep it.
    task automatic set_mode(input logic [2:0] m, input logic [3:0] c);
        hb = {4'h0, m[2], 3'h0};
        wr(ADDR_CTRL_B, hb, RESP_OKAY);
        wr(ADDR_CTRL_A, {c, 2'h0, m[1:0]}, RESP_OKAY);
    endtask
    task automatic run;
        wr(ADDR_CTRL_B, hb | 8'h01, RESP_OKAY);
        repeat (20) @(posedge i_mclk);
        wr(ADDR_CTRL_B, hb, RESP_OKAY);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_mismatch++;
        $display("mismatch at %0t: run did not finish", $time);
        complete_run;
    end
    initial begin
        i_rst_b = 1'b0;
        i_ext_pin = 1'b0;
        i_awaddr = 8'h00;
        i_awvalid = 1'b0;
        i_wdata = 32'h0;
        i_wstrb = 4'hf;
        i_wvalid = 1'b0;
        i_bready = 1'b0;
        i_araddr = 8'h00;
        i_arvalid = 1'b0;
        i_rready = 1'b0;
        hb = 8'h00;
        exp_a = 1'b0;
        do_reset;
        rd(ADDR_CTRL_A, 8'h00, RESP_OKAY);
        rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL_A, tbl[i], RESP_OKAY);
            rd(ADDR_CTRL_A, tbl[i] & 8'hf3, RESP_OKAY);
            chk1(o_wave_en_a, (tbl[i][7:6] == 2'h1) ? !tbl[i][0] : |tbl[i][7:6]);
            chk1(o_wave_en_b, |tbl[i][5:4]);
        end
        wr(ADDR_CTRL_B, 8'h08, RESP_OKAY);
        rd(ADDR_CTRL_B, 8'h08, RESP_OKAY);
        wr(8'h80, 8'h55, RESP_SLVERR);
        rd(8'h80, 8'h00, RESP_SLVERR);
        wr(8'h31, 8'h55, RESP_SLVERR);
        $display("test registers done");
        do_reset;
        wr(ADDR_CMP_A, 8'h10, RESP_OKAY);
        wr(ADDR_CMP_B, 8'h10, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_COUNTER, 8'h08, RESP_OKAY);
            set_mode(3'h0, {cds[i], cds[i]});
            run;
            if (cds[i] == 2'h3) exp_a = 1'b1;
            else if (cds[i] == 2'h2) exp_a = 1'b0;
            else if (cds[i] == 2'h1) exp_a = ~exp_a;
            chk1(o_wave_out_a, exp_a);
            chk1(o_wave_out_b, exp_a);
        end
        rd(ADDR_FLAGS, 8'h06, RESP_OKAY);
        chk({30'h0, o_match_b_flag, o_match_a_flag}, 32'h3);
        wr(ADDR_FLAGS, 8'h07, RESP_OKAY);
        rd(ADDR_FLAGS, 8'h00, RESP_OKAY);
        $display("test match codes done");
        for (int i = 0; i < 5; i++) begin
            do_reset;
            wr(ADDR_CMP_A, 8'hf8, RESP_OKAY);
            wr(ADDR_COUNTER, 8'hf0, RESP_OKAY);
            set_mode(mds[i], 4'h0);
            run;
            chk1(o_overflow_flag, ovx[i]);
        end
        $display("test overflow modes done");
        do_reset;
        wr(ADDR_CMP_A, 8'hff, RESP_OKAY);
        wr(ADDR_CMP_B, 8'h40, RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_COUNTER, 8'hf0, RESP_OKAY);
            set_mode(3'h3, (i == 0) ? 4'hb : 4'he);
            run;
            chk1(o_wave_out_a, i == 0);
            chk1(o_wave_out_b, i == 1);
        end
        $display("test fast pwm done");
        do_reset;
        wr(ADDR_CMP_A, 8'h20, RESP_OKAY);
        wr(ADDR_CMP_B, 8'hff, RESP_OKAY);
        set_mode(3'h1, 4'he);
        wr(ADDR_COUNTER, 8'h18, RESP_OKAY);
        run;
        chk1(o_wave_out_a, 1'b1);
        chk1(o_wave_out_b, 1'b0);
        wr(ADDR_COUNTER, 8'hf0, RESP_OKAY);
        run;
        chk1(o_wave_out_b, 1'b1);
        wr(ADDR_COUNTER, 8'h28, RESP_OKAY);
        run;
        chk1(o_wave_out_a, 1'b0);
        $display("test phase pwm done");
        complete_run;
    end
endmodule // timer8_wave_ctrl_bench
`default_nettype wire
